// ### pkg/port_a_pkg.sv
// Constants shared by the port A pin readback and function select block.
// Notes on behaviour
// RQ1 - Two read-only 16-bit pin level registers.
// RQ2 - Reads return pin levels regardless of function.
// RQ3 - Pin 26 field bits 10:8, four codes.
// RQ4 - Pin 25 field bits 6:4, four codes.
// RQ5 - Pin 24 field bits 1:0, four codes.
// RQ6 - Reserved bits 7,3,2 read zero, write zero.
// RQ7 - Software never writes codes 100 to 111.
// RQ8 - Route selected peripheral signal to pin.
package port_a_pkg;
  localparam logic [3:0]  ADDR_UPPER_LEVELS = 4'h0;
  localparam logic [3:0]  ADDR_LOWER_LEVELS = 4'h4;
  localparam logic [3:0]  ADDR_FUNC_SELECT  = 4'h8;
  localparam int          PIN_COUNT         = 32;
  localparam int          REG_WIDTH         = 16;
  localparam int          P26_MSB           = 10;
  localparam int          P26_LSB           = 8;
  localparam int          P25_MSB           = 6;
  localparam int          P25_LSB           = 4;
  localparam int          P24_MSB           = 1;
  localparam int          P24_LSB           = 0;
  localparam logic [15:0] FUNC_WRITE_MASK   = 16'h0773;
  localparam logic [2:0]  FUNC3_RESET       = 3'h0;
  localparam logic [1:0]  FUNC2_RESET       = 2'h0;
  localparam logic [2:0]  F3_GPIO           = 3'h0;
  localparam logic [2:0]  F3_ADDR           = 3'h1;
  localparam logic [2:0]  F3_DMA            = 3'h2;
  localparam logic [2:0]  F3_IRQ            = 3'h3;
  localparam logic [1:0]  F2_GPIO           = 2'h0;
  localparam logic [1:0]  F2_ADDR           = 2'h1;
  localparam logic [1:0]  F2_DMA            = 2'h2;
  localparam logic [1:0]  F2_IRQ            = 2'h3;
endpackage

// ### hw/pin_level_sampler.sv
// Sampling register that captures the live level of all port pins.
`timescale 1ns/1ns
module pin_level_sampler (
  input  wire logic        core_clk_i, // Core clock.
  input  wire logic        rst_n_i,    // Asynchronous reset, active low.
  input  wire logic [31:0] pins_i,     // Live pin levels.
  output logic      [31:0] levels_o    // Registered pin levels.
);
  // One register stage; pins are taken as synchronous to the clock.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      levels_o <= 32'h0000_0000;
    end else begin
      levels_o <= pins_i; // RQ2
    end
  end
endmodule

// ### hw/port_a_pin_mux.sv
// Port A pin level readback, function select and pin routing for pins 24 to 26.
`timescale 1ns/1ns
module port_a_pin_mux (
  input  wire logic        core_clk_i,          // Core clock, 250 MHz.
  input  wire logic        rst_n_i,             // Asynchronous reset, active low.
  input  wire logic        wb_cyc_i,            // Wishbone cycle.
  input  wire logic        wb_stb_i,            // Wishbone strobe.
  input  wire logic        wb_we_i,             // Wishbone write enable.
  input  wire logic [3:0]  wb_adr_i,            // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,            // Wishbone byte selects.
  input  wire logic [31:0] wb_dat_i,            // Wishbone write data.
  output logic      [31:0] wb_dat_o,            // Wishbone read data.
  output logic             wb_ack_o,            // Wishbone acknowledge.
  input  wire logic [31:0] pin_i,               // Pin pad input levels.
  input  wire logic [2:0]  gpio_out_i,          // Port output data for pins 24 to 26.
  input  wire logic [2:0]  gpio_oe_i,           // Port output enables for pins 24 to 26.
  input  wire logic [2:0]  address_line_i,      // Bus controller address lines 24 to 26.
  input  wire logic        dma_transfer_end_ch3_i, // DMA transfer end, channel 3.
  input  wire logic        dma_acknowledge_ch3_i,  // DMA acknowledge, channel 3.
  output logic      [2:0]  pin_o,               // Pad output data for pins 24 to 26.
  output logic      [2:0]  pin_oe_o,            // Pad output enables for pins 24 to 26.
  output logic             dma_request_ch3_o,   // DMA request, channel 3.
  output logic             pin_interrupt_0_alt_o, // Interrupt input 0 from pin 24.
  output logic             pin_interrupt_1_alt_o, // Interrupt input 1 from pin 25.
  output logic             pin_interrupt_2_alt_o  // Interrupt input 2 from pin 26.
);
  import port_a_pkg::*;

  // Registered pin levels from the sampler.
  logic [31:0] levels;
  // Function fields, one register for each pin.
  logic [2:0]  pin26_function_field_reg;
  logic [2:0]  pin25_function_field_reg;
  logic [1:0]  pin24_function_field_reg;
  // Bus decode and read path.
  logic [15:0] func_word;
  logic        bus_req;
  logic        wr_func;
  logic [31:0] rd_next;
  // Next pad drive, registered before it reaches the pads.
  logic [2:0]  pin_next;
  logic [2:0]  oe_next;

  // Pin levels pass one register, then the read data register, so readback is two cycles behind the pad.
  pin_level_sampler u_sampler (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .pins_i     (pin_i),
    .levels_o   (levels)
  );

  // Single-cycle classic Wishbone: ack follows the request and drops after one cycle.
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_func = bus_req && wb_we_i && (wb_adr_i == ADDR_FUNC_SELECT);

  // Assembled function select word; reserved bits stay zero.
  assign func_word = {5'h00, pin26_function_field_reg, 1'b0, pin25_function_field_reg,
                      2'h0, pin24_function_field_reg}; // RQ6

  // Acknowledge is a one-cycle pulse; a request still held is taken again on the cycle after ack drops.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Pin 26 field lives in byte lane 1 of the function select word.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin26_function_field_reg <= FUNC3_RESET; // RQ3
    end else if (wr_func && wb_sel_i[1]) begin
      pin26_function_field_reg <= wb_dat_i[P26_MSB:P26_LSB]; // RQ3
    end
  end

  // Pin 25 field lives in byte lane 0; prohibited codes are stored as written.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin25_function_field_reg <= FUNC3_RESET; // RQ4
    end else if (wr_func && wb_sel_i[0]) begin
      pin25_function_field_reg <= wb_dat_i[P25_MSB:P25_LSB]; // RQ4
    end
  end

  // Pin 24 field shares byte lane 0 with pin 25.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin24_function_field_reg <= FUNC2_RESET; // RQ5
    end else if (wr_func && wb_sel_i[0]) begin
      pin24_function_field_reg <= wb_dat_i[P24_MSB:P24_LSB]; // RQ5
    end
  end

  // Read mux; pin level registers ignore writes and unmapped reads return zero.
  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (wb_adr_i)
      ADDR_UPPER_LEVELS: rd_next = {16'h0000, levels[31:16]}; // RQ1
      ADDR_LOWER_LEVELS: rd_next = {16'h0000, levels[15:0]};  // RQ1
      ADDR_FUNC_SELECT:  rd_next = {16'h0000, func_word & FUNC_WRITE_MASK}; // RQ6
      default:           rd_next = 32'h0000_0000;
    endcase
  end

  // Read data is captured only on a read, so it holds until the next one.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= rd_next;
    end
  end

  // Pad drive for a pin with a 3-bit field, returned as {enable, data}. Prohibited codes
  // fall back to the port function so the pad is never driven by an unexpected source;
  // software is expected not to write them anyway.
  function automatic logic [1:0] wide_drive(input logic [2:0] code,
                                            input logic       port_out,
                                            input logic       port_oe,
                                            input logic       bus_addr,
                                            input logic       dma_out);
    logic [1:0] drive;
    drive = {port_oe, port_out};
    case (code)
      F3_ADDR: begin
        drive = {1'b1, bus_addr}; // RQ8
      end
      F3_DMA: begin
        drive = {1'b1, dma_out}; // RQ8
      end
      F3_IRQ: begin
        drive = {1'b0, port_out}; // RQ8
      end
      default: begin
        drive = {port_oe, port_out}; // RQ7
      end
    endcase
    return drive;
  endfunction

  // Level handed to a peripheral input. It rests low while the pin serves another
  // function, so port traffic is never seen as a request or an interrupt.
  function automatic logic forward_level(input logic selected, input logic level);
    return selected && level;
  endfunction

  // Pad routing; every 2-bit code of pin 24 is legal, so its case needs no default.
  always_comb begin
    pin_next = gpio_out_i;
    oe_next  = gpio_oe_i;
    unique case (pin24_function_field_reg)
      F2_GPIO: begin
        oe_next[0] = gpio_oe_i[0]; // RQ5
      end
      F2_ADDR: begin
        pin_next[0] = address_line_i[0]; // RQ8
        oe_next[0]  = 1'b1;
      end
      F2_DMA, F2_IRQ: begin
        oe_next[0] = 1'b0; // RQ8
      end
    endcase
    {oe_next[1], pin_next[1]} = wide_drive(pin25_function_field_reg, gpio_out_i[1], gpio_oe_i[1],
                                           address_line_i[1], dma_acknowledge_ch3_i); // RQ4
    {oe_next[2], pin_next[2]} = wide_drive(pin26_function_field_reg, gpio_out_i[2], gpio_oe_i[2],
                                           address_line_i[2], dma_transfer_end_ch3_i); // RQ3
  end

  // Pad data passes one register so decode glitches never reach the pads.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o <= 3'h0;
    end else begin
      pin_o <= pin_next; // RQ8
    end
  end

  // Enables rest low in reset, so every pad starts as an input until software acts.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_oe_o <= 3'h0;
    end else begin
      pin_oe_o <= oe_next; // RQ8
    end
  end

  // DMA request from pin 24; it lags the pad by two cycles, sampler then this stage.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dma_request_ch3_o <= 1'b0;
    end else begin
      dma_request_ch3_o <= forward_level(pin24_function_field_reg == F2_DMA, levels[24]); // RQ8
    end
  end

  // Interrupt input 0 from pin 24.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_interrupt_0_alt_o <= 1'b0;
    end else begin
      pin_interrupt_0_alt_o <= forward_level(pin24_function_field_reg == F2_IRQ, levels[24]); // RQ8
    end
  end

  // Interrupt input 1 from pin 25.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_interrupt_1_alt_o <= 1'b0;
    end else begin
      pin_interrupt_1_alt_o <= forward_level(pin25_function_field_reg == F3_IRQ, levels[25]); // RQ8
    end
  end

  // Interrupt input 2 from pin 26.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_interrupt_2_alt_o <= 1'b0;
    end else begin
      pin_interrupt_2_alt_o <= forward_level(pin26_function_field_reg == F3_IRQ, levels[26]); // RQ8
    end
  end
endmodule

// ### verif/port_a_pin_mux_properties.sv
// Checker on the ports of the port A pin mux.
`timescale 1ns/1ns
module port_a_pin_mux_properties (
  input wire logic        core_clk_i,             // Clock.
  input wire logic        rst_n_i,                // Reset.
  input wire logic        wb_cyc_i,               // Cycle.
  input wire logic        wb_stb_i,               // Strobe.
  input wire logic        wb_we_i,                // Write.
  input wire logic [3:0]  wb_adr_i,               // Address.
  input wire logic [3:0]  wb_sel_i,               // Byte selects.
  input wire logic [31:0] wb_dat_i,               // Write data.
  input wire logic [31:0] wb_dat_o,               // Read data.
  input wire logic        wb_ack_o,               // Ack.
  input wire logic [31:0] pin_i,                  // Pads.
  input wire logic [2:0]  address_line_i,         // Address lines.
  input wire logic        dma_transfer_end_ch3_i, // Transfer end.
  input wire logic [2:0]  pin_o,                  // Pad data.
  input wire logic [2:0]  pin_oe_o,               // Pad enables.
  input wire logic        pin_interrupt_0_alt_o   // Interrupt 0.
);
  logic [1:0] f24_reg;
  logic [2:0] f26_reg;
  // Shadow fields; the route checks wait for an idle bus so the design has settled.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      f24_reg <= 2'h0;
      f26_reg <= 3'h0;
    end else if (wb_ack_o && wb_we_i && wb_adr_i == 4'h8) begin
      if (wb_sel_i[0]) begin
        f24_reg <= wb_dat_i[1:0];
      end
      if (wb_sel_i[1]) begin
        f26_reg <= wb_dat_i[10:8];
      end
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_ack_timing: assert property (wb_ack_o == $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("ack timing");
  a_upper_levels: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |->
    wb_dat_o == {16'h0000, $past(pin_i[31:16], 2)})
    else $error("upper levels");
  a_lower_levels: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h4 |->
    wb_dat_o == {16'h0000, $past(pin_i[15:0], 2)})
    else $error("lower levels");
  a_reserved_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h8 |->
    wb_dat_o[7] == 1'b0 && wb_dat_o[3:2] == 2'h0)
    else $error("reserved bits");
  a_input_undriven: assert property (!wb_cyc_i && $stable(f24_reg) && f24_reg[1] |-> !pin_oe_o[0])
    else $error("input pin driven");
  a_addr_route: assert property (!wb_cyc_i && $stable(f24_reg) && f24_reg == 2'h1 |->
    pin_oe_o[0] && pin_o[0] == $past(address_line_i[0]))
    else $error("address route");
  a_irq_route: assert property (!wb_cyc_i && f24_reg == 2'h3 && $past(f24_reg, 2) == 2'h3 |->
    pin_interrupt_0_alt_o == $past(pin_i[24], 2))
    else $error("interrupt route");
  a_dma_route: assert property (!wb_cyc_i && $stable(f26_reg) && f26_reg == 3'h2 |->
    pin_oe_o[2] && pin_o[2] == $past(dma_transfer_end_ch3_i))
    else $error("transfer end route");
endmodule
bind port_a_pin_mux port_a_pin_mux_properties chk (
  .core_clk_i             (core_clk_i),
  .rst_n_i                (rst_n_i),
  .wb_cyc_i               (wb_cyc_i),
  .wb_stb_i               (wb_stb_i),
  .wb_we_i                (wb_we_i),
  .wb_adr_i               (wb_adr_i),
  .wb_sel_i               (wb_sel_i),
  .wb_dat_i               (wb_dat_i),
  .wb_dat_o               (wb_dat_o),
  .wb_ack_o               (wb_ack_o),
  .pin_i                  (pin_i),
  .address_line_i         (address_line_i),
  .dma_transfer_end_ch3_i (dma_transfer_end_ch3_i),
  .pin_o                  (pin_o),
  .pin_oe_o               (pin_oe_o),
  .pin_interrupt_0_alt_o  (pin_interrupt_0_alt_o)
);

// ### verif/pad_model.sv
// Model of the pads and peripheral sources around port A.
`timescale 1ns/1ns
module pad_model (
  input  wire logic        clk_i,    // Clock.
  input  wire logic        step_i,   // Draw new outside levels.
  input  wire logic [2:0]  drv_i,    // Pad data from the block.
  input  wire logic [2:0]  drv_oe_i, // Pad enables from the block.
  output logic      [31:0] pad_o,    // Resolved pad levels.
  output logic      [2:0]  addr_o,   // Address lines.
  output logic             dact_o,   // Transfer end.
  output logic             dack_o    // Acknowledge.
);
  logic [31:0] ext_reg = 32'h0000_0000;
  initial {addr_o, dact_o, dack_o} = 5'h00;
  // Levels change only on request, so the bench reads settled pads.
  always @(posedge clk_i) begin
    if (step_i) begin
      ext_reg <= $urandom;
      {addr_o, dact_o, dack_o} <= 5'($urandom);
    end
  end
  // A driven pad shows its driver, the others the outside level.
  assign pad_o = {ext_reg[31:27], (drv_oe_i & drv_i) | (~drv_oe_i & ext_reg[26:24]), ext_reg[23:0]};
endmodule

// ### verif/port_a_pin_mux_test.sv
// Self-checking bench for the port A pin mux.
`timescale 1ns/1ns
module port_a_pin_mux_test;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, step = 1'b0, ack, dreq, dact, dack;
  logic [3:0] adr = 4'h0, sel = 4'hf;
  logic [31:0] wdat = 32'h0000_0000, rdat, pads, q, fs;
  logic [2:0] gout = 3'h0, goe = 3'h0, aline, po, poe, irq;
  logic [1:0] c;
  int failures = 0, samples_checked = 0;
  always #2 clk = ~clk;
  port_a_pin_mux dut (.core_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pin_i(pads),
    .gpio_out_i(gout), .gpio_oe_i(goe), .address_line_i(aline), .dma_transfer_end_ch3_i(dact),
    .dma_acknowledge_ch3_i(dack), .pin_o(po), .pin_oe_o(poe), .dma_request_ch3_o(dreq),
    .pin_interrupt_0_alt_o(irq[0]), .pin_interrupt_1_alt_o(irq[1]), .pin_interrupt_2_alt_o(irq[2]));
  pad_model far (.clk_i(clk), .step_i(step), .drv_i(po), .drv_oe_i(poe), .pad_o(pads), .addr_o(aline),
    .dact_o(dact), .dack_o(dack));
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; the request holds until ack is sampled high.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) begin
      failures++;
      results();
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // Expected {enables, driven data, request, interrupts} for one code.
  function automatic logic [9:0] route(input logic [1:0] k);
    case (k)
      2'h0: return {goe, gout & goe, 4'h0};
      2'h1: return {3'h7, aline, 4'h0};
      2'h2: return {3'h6, dact, dack, 1'b0, pads[24], 3'h0};
      default: return {7'h00, pads[26:24]};
    endcase
  endfunction
  initial begin
    void'($urandom(32'h9522_58c2));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, 4'h8, 32'h0000_0000, q);
    check(q, 32'h0000_0000);
    bus(1'b0, 4'hc, 32'h0000_0000, q);
    check(q, 32'h0000_0000);
    for (int i = 0; i < 24; i++) begin
      c = 2'(i);
      fs = {21'h0_0000, 1'b0, c, 2'h0, c, 2'h0, c};
      bus(1'b1, 4'h8, fs, q);
      bus(1'b1, {1'b0, i[0], 2'h0}, $urandom, q);
      bus(1'b0, 4'h8, 32'h0000_0000, q);
      check(q, fs);
      step <= 1'b1;
      gout <= 3'($urandom);
      goe <= 3'($urandom);
      @(posedge clk);
      step <= 1'b0;
      repeat (4) @(posedge clk);
      check({22'h0_0000, poe, po & poe, dreq, irq}, {22'h0_0000, route(c)});
      bus(1'b0, 4'h0, 32'h0000_0000, q);
      check(q, {16'h0000, pads[31:16]});
      bus(1'b0, 4'h4, 32'h0000_0000, q);
      check(q, {16'h0000, pads[15:0]});
    end
    // Corner case: byte lane 1 alone clears only the pin 26 field of the last pattern.
    sel <= 4'h2;
    bus(1'b1, 4'h8, 32'h0000_0000, q);
    sel <= 4'hf;
    bus(1'b0, 4'h8, 32'h0000_0000, q);
    check(q, 32'h0000_0033);
    results();
  end
endmodule
